/* core/sdbg_pkg.sv */
// Constants and types of the single-pin debug command decoder.
// Assumes a single debug clock of 125 MHz drives every register.
package sdbg_pkg;
  // ------------------------------------------------------------------
  // Link timing, in debug clock cycles
  // ------------------------------------------------------------------
  localparam int unsigned SYNC_LOW_MIN_CYC  = 128;
  localparam int unsigned SYNC_GAP_CYC      = 16;
  localparam int unsigned SYNC_REPLY_LO_CYC = 128;
  localparam int unsigned SYNC_REPLY_HI_CYC = 1;
  localparam int unsigned SYNC_CNT_W        = 8;
  // ------------------------------------------------------------------
  // Command codes and fields
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_NOP        = 8'h00;
  localparam logic [7:0] CMD_PC_CAPTURE = 8'h01;
  localparam logic [7:0] CMD_ACK_ENABLE = 8'h02;
  localparam logic [7:0] CMD_ACK_DISABLE = 8'h03;
  localparam logic [7:0] CMD_GO         = 8'h08;
  localparam logic [7:0] CMD_STATUS_WR  = 8'h0d;
  localparam logic [7:0] CMD_CTRL2_WR   = 8'h0e;
  localparam logic [7:0] CMD_CTRL3_WR   = 8'h0f;
  localparam logic [7:0] CMD_STATUS_RD  = 8'h2d;
  localparam logic [7:0] CMD_CTRL2_RD   = 8'h2e;
  localparam logic [7:0] CMD_CTRL3_RD   = 8'h2f;
  localparam logic [3:0] GRP_MEM_WR     = 4'h1;
  localparam logic [3:0] GRP_MEM_RD     = 4'h3;
  localparam logic [3:0] GRP_TRACE_GPR  = 4'h4;
  localparam logic [3:0] GRP_GPR_RD     = 4'h6;
  localparam logic [2:0] GRP_DBG_WR     = 3'h4;
  localparam logic [2:0] GRP_CPU_WR     = 3'h6;
  localparam logic [1:0] SEL_STATUS     = 2'h1;
  localparam logic [1:0] SEL_CTRL2      = 2'h2;
  localparam logic [1:0] SZ_BYTE        = 2'b00;
  localparam logic [1:0] SZ_WORD        = 2'b01;
  localparam logic [1:0] SZ_LONG        = 2'b10;
  localparam logic [2:0] ADDR_BYTES     = 3'h3;
  localparam logic [2:0] LONG_BYTES     = 3'h4;
  localparam int unsigned TX_FIFO_DEPTH = 16;

  typedef enum logic [3:0] {
    OP_NOP, OP_ACK_EN, OP_ACK_DIS, OP_GO, OP_PC_CAP, OP_MEM_RD, OP_MEM_WR, OP_TRACE_RD,
    OP_GPR_RD, OP_GPR_WR, OP_CPU_WR, OP_DBG_WR, OP_BYTE_RD, OP_BYTE_WR, OP_ILLEGAL
  } sdbg_op_type;

  // Decoded shape of one command.
  typedef struct packed {
    sdbg_op_type op;
    logic [1:0]  size;
    logic        with_status;
    logic        has_addr;
    logic [2:0]  data_bytes;
    logic        acks;
  } sdbg_cmd_info_type;

  // One access handed to the processor side.
  typedef struct packed {
    sdbg_op_type op;
    logic [1:0]  size;
    logic [4:0]  reg_num;
    logic [23:0] addr;
    logic [31:0] wdata;
  } sdbg_acc_req_type;
endpackage

/* core/sdbg_byte_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two and one clock for both sides.
module sdbg_byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  wire              full_w  = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                              (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  wire              empty_w = (wr_ptr_q == rd_ptr_q);
  wire              push_w  = wr_valid_in && !full_w;
  wire              pop_w   = rd_ready_in && !empty_w;

  assign wr_ready_out = !full_w;
  assign rd_valid_out = !empty_w;
  assign rd_data_out  = mem_q[rd_ptr_q[AW-1:0]];

  // Storage is written only when a slot is free.
  always_ff @(posedge clk_in) begin
    if (push_w) begin
      mem_q[wr_ptr_q[AW-1:0]] <= wr_data_in;
    end
  end

  // Pointers carry one wrap bit so that full and empty differ.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + (AW+1)'(push_w);
      rd_ptr_q <= rd_ptr_q + (AW+1)'(pop_w);
    end
  end
endmodule

/* core/sdbg_cmd_decoder.sv */
// Command decoder and link control of the single-pin debug port.
// Assumes a bit framer on the same clock delivers and takes whole bytes,
// and a processor side that completes each access with a done pulse.
// Function
// - Size field codes byte 00, word 01, longword 10.
// - Status byte is the top byte of the extended status register.
// - Memory read 0x30+4sz, address, delay, data; 0x31 variant adds status first.
// - Memory write 0x10+4sz, address, data, delay; 0x11 variant returns status.
// - 0x40+n reads a trace buffer longword while the processor runs.
// - 0x60+n reads a processor register, only while halted.
// - 0x40+n with 32 data bits writes a processor register while halted.
// - 0xC0+n with 32 data bits writes a control register while halted.
// - 0x80+n with 32 data bits writes a debug control register.
// - 0x2D to 0x2F return a control byte at once, never acknowledged.
// - 0x0D to 0x0F load a control byte, never acknowledged.
// - 0x01 captures the program counter into the trace buffer.
// - Only acknowledging commands pulse acknowledge, and only with handshake on, except 0x02, which pulses it even while off.
// - A sync request is known only by a very long low on the pin.
// - Resume while running does nothing.
// - After the long low, wait for high, then wait 16 cycles.
// - Drive low 128 cycles, high one cycle, then release.
// - 0x03 turns handshake off and is itself not acknowledged.
// - Handshake enable acts locally, is acknowledged, enables later handshakes.
module sdbg_cmd_decoder (
  input  wire logic                      ref_clk_in,
  input  wire logic                      resetn_in,
  input  wire logic                      debug_pin_in,
  output logic                           debug_pin_out,
  output logic                           debug_pin_oe_n_out,
  input  wire logic [7:0]                rx_byte_in,
  input  wire logic                      rx_valid_in,
  output logic                           rx_ready_out,
  output logic      [7:0]                tx_byte_out,
  output logic                           tx_valid_out,
  input  wire logic                      tx_ready_in,
  output logic                           ack_pulse_out,
  output logic                           ack_enabled_out,
  output logic                           illegal_cmd_out,
  input  wire logic                      halted_in,
  output logic                           resume_out,
  output logic                           acc_valid_out,
  output sdbg_pkg::sdbg_acc_req_type     acc_req_out,
  input  wire logic                      acc_done_in,
  input  wire logic [31:0]               acc_rdata_in,
  output logic      [7:0]                ext_debug_status_reg_out,
  output logic      [7:0]                debug_ctrl_reg_two_out,
  output logic      [7:0]                debug_ctrl_reg_three_out
);
  import sdbg_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_ARGS = 4'b0010, ST_EXEC = 4'b0100, ST_RESP = 4'b1000
  } sdbg_state_type;
  typedef enum logic [4:0] {
    SY_IDLE = 5'b00001, SY_WAIT_HI = 5'b00010, SY_GAP = 5'b00100,
    SY_LOW = 5'b01000, SY_HIGH = 5'b10000
  } sdbg_sync_type;

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------
  // Operand size to byte count.
  function automatic logic [2:0] size_bytes(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: size_bytes = 3'h1;
      SZ_WORD: size_bytes = 3'h2;
      default: size_bytes = LONG_BYTES;
    endcase
  endfunction

  // Command code to command shape, given the run or halt state.
  function automatic sdbg_cmd_info_type decode(input logic [7:0] c, input logic halted);
    sdbg_cmd_info_type i;
    logic              sz_ok;
    sz_ok        = (c[3:2] != 2'b11);
    i            = '{op: OP_ILLEGAL, size: SZ_LONG, with_status: 1'b0, has_addr: 1'b0,
                     data_bytes: 3'h0, acks: 1'b1};
    case (c)
      CMD_NOP:         i.op = OP_NOP;
      CMD_PC_CAPTURE:  i.op = OP_PC_CAP;
      CMD_ACK_ENABLE:  i.op = OP_ACK_EN;
      CMD_ACK_DISABLE: i.op = OP_ACK_DIS;
      CMD_GO:          i.op = OP_GO;
      CMD_STATUS_WR, CMD_CTRL2_WR, CMD_CTRL3_WR: begin
        i.op         = OP_BYTE_WR;
        i.data_bytes = 3'h1;
      end
      CMD_STATUS_RD, CMD_CTRL2_RD, CMD_CTRL3_RD: i.op = OP_BYTE_RD;
      default: begin
        if ((c[7:4] == GRP_MEM_WR || c[7:4] == GRP_MEM_RD) && sz_ok && !c[1]) begin
          i.op          = (c[7:4] == GRP_MEM_WR) ? OP_MEM_WR : OP_MEM_RD;
          i.size        = c[3:2];
          i.with_status = c[0];
          i.has_addr    = 1'b1;
          i.data_bytes  = (c[7:4] == GRP_MEM_WR) ? size_bytes(c[3:2]) : 3'h0;
        end else if (c[7:4] == GRP_TRACE_GPR) begin
          i.op         = halted ? OP_GPR_WR : OP_TRACE_RD;
          i.data_bytes = halted ? LONG_BYTES : 3'h0;
        end else if (c[7:4] == GRP_GPR_RD && halted) begin
          i.op = OP_GPR_RD;
        end else if (c[7:5] == GRP_DBG_WR) begin
          i.op         = OP_DBG_WR;
          i.data_bytes = LONG_BYTES;
        end else if (c[7:5] == GRP_CPU_WR && halted) begin
          i.op         = OP_CPU_WR;
          i.data_bytes = LONG_BYTES;
        end
      end
    endcase
    i.acks = !i.with_status && !(i.op inside {OP_ACK_DIS, OP_BYTE_RD, OP_BYTE_WR,
                                               OP_ILLEGAL});
    return i;
  endfunction

  // ------------------------------------------------------------------
  // Reset release and pin synchroniser
  // ------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic       pin_meta_q;
  logic       pin_sync_q;

  // Reset asserts at once and releases after two clock edges.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // The pin level passes two flip-flops before anything reads it.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end else begin
      pin_meta_q <= debug_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // Speed synchronisation
  // ------------------------------------------------------------------
  sdbg_sync_type         sy_q;
  sdbg_sync_type         sy_d;
  logic [SYNC_CNT_W-1:0] low_cnt_q;
  logic [SYNC_CNT_W-1:0] sy_cnt_q;
  logic [SYNC_CNT_W-1:0] sy_cnt_d;
  wire                   sync_req_w = (sy_q == SY_IDLE) && !pin_sync_q &&
                           (low_cnt_q == SYNC_CNT_W'(SYNC_LOW_MIN_CYC - 1));

  // Walks wait-high, gap, low reply and high pulse.
  always_comb begin
    sy_d     = sy_q;
    sy_cnt_d = sy_cnt_q + 1'b1;
    case (sy_q)
      SY_IDLE: begin
        sy_cnt_d = '0;
        if (sync_req_w) sy_d = SY_WAIT_HI;
      end
      SY_WAIT_HI: begin
        sy_cnt_d = '0;
        if (pin_sync_q) sy_d = SY_GAP;
      end
      SY_GAP: if (sy_cnt_q == SYNC_CNT_W'(SYNC_GAP_CYC - 1)) begin
        sy_d     = SY_LOW;
        sy_cnt_d = '0;
      end
      SY_LOW: if (sy_cnt_q == SYNC_CNT_W'(SYNC_REPLY_LO_CYC - 1)) begin
        sy_d     = SY_HIGH;
        sy_cnt_d = '0;
      end
      SY_HIGH: if (sy_cnt_q == SYNC_CNT_W'(SYNC_REPLY_HI_CYC - 1)) begin
        sy_d = SY_IDLE;
      end
      default: sy_d = SY_IDLE;
    endcase
  end

  // Low time counts only while idle and saturates at the threshold.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sy_q               <= SY_IDLE;
      sy_cnt_q           <= '0;
      low_cnt_q          <= '0;
      debug_pin_out      <= 1'b1;
      debug_pin_oe_n_out <= 1'b1;
    end else begin
      sy_q               <= sy_d;
      sy_cnt_q           <= sy_cnt_d;
      low_cnt_q          <= (pin_sync_q || sy_q != SY_IDLE) ? '0 :
                            low_cnt_q + SYNC_CNT_W'(!sync_req_w);
      debug_pin_out      <= (sy_d == SY_HIGH);
      debug_pin_oe_n_out <= !(sy_d == SY_LOW || sy_d == SY_HIGH);
    end
  end

  // ------------------------------------------------------------------
  // Command decoding and execution
  // ------------------------------------------------------------------
  sdbg_state_type    st_q;
  sdbg_cmd_info_type info_q;
  logic [7:0]        cmd_q;
  logic [55:0]       arg_q;
  logic [2:0]        cnt_q;
  logic [39:0]       resp_q;
  logic [2:0]        resp_cnt_q;
  logic              ack_en_q;
  logic [7:0]        ext_debug_status_reg_q;
  logic [7:0]        ctrl2_q;
  logic [7:0]        ctrl3_q;
  logic              fifo_ready;

  wire sdbg_cmd_info_type rx_info_w = decode(rx_byte_in, halted_in);
  wire [2:0] rx_nargs_w  = (rx_info_w.has_addr ? ADDR_BYTES : 3'h0) + rx_info_w.data_bytes;
  wire       busy_w      = (sy_q != SY_IDLE) || sync_req_w;
  wire       rx_take_w   = rx_valid_in && rx_ready_out;
  wire       local_w     = !(info_q.op inside {OP_PC_CAP, OP_MEM_RD, OP_MEM_WR, OP_TRACE_RD,
                                               OP_GPR_RD, OP_GPR_WR, OP_CPU_WR, OP_DBG_WR});
  wire       done_w      = (st_q == ST_EXEC) && (local_w || acc_done_in);
  wire [2:0] db_w        = info_q.data_bytes;
  wire [7:0] byte_sel_w  = (cmd_q[1:0] == SEL_STATUS) ? ext_debug_status_reg_q :
                           (cmd_q[1:0] == SEL_CTRL2) ? ctrl2_q : ctrl3_q;
  wire [31:0] rd_al_w    = (info_q.size == SZ_BYTE) ? {acc_rdata_in[7:0], 24'h000000} :
                           (info_q.size == SZ_WORD) ? {acc_rdata_in[15:0], 16'h0000} :
                           acc_rdata_in;
  wire [2:0] rd_n_w      = size_bytes(info_q.size);
  // Responses are left aligned and leave most significant byte first.
  wire [39:0] resp_w     = (info_q.op == OP_BYTE_RD) ? {byte_sel_w, 32'h00000000} :
                           (info_q.op == OP_MEM_WR) ? {ext_debug_status_reg_q, 32'h00000000} :
                           (info_q.op == OP_MEM_RD && info_q.with_status) ?
                             {ext_debug_status_reg_q, rd_al_w} :
                           (info_q.op == OP_MEM_RD) ? {rd_al_w, 8'h00} :
                           {acc_rdata_in, 8'h00};
  wire [2:0] resp_n_w    = (info_q.op == OP_BYTE_RD) ? 3'h1 :
                           (info_q.op == OP_MEM_WR) ? 3'(info_q.with_status) :
                           (info_q.op == OP_MEM_RD) ? rd_n_w + 3'(info_q.with_status) :
                           (info_q.op inside {OP_TRACE_RD, OP_GPR_RD}) ? LONG_BYTES : 3'h0;
  wire       ack_w       = done_w && info_q.acks && (ack_en_q || info_q.op == OP_ACK_EN);

  assign rx_ready_out    = !busy_w && (st_q == ST_IDLE || st_q == ST_ARGS);
  assign acc_valid_out   = (st_q == ST_EXEC) && !local_w;
  assign acc_req_out.op      = info_q.op;
  assign acc_req_out.size    = info_q.size;
  assign acc_req_out.reg_num = cmd_q[4:0];
  assign acc_req_out.addr    = (db_w == 3'h0) ? arg_q[23:0] : (db_w == 3'h1) ? arg_q[31:8] :
                               (db_w == 3'h2) ? arg_q[39:16] : arg_q[55:32];
  assign acc_req_out.wdata   = (db_w == 3'h1) ? {24'h000000, arg_q[7:0]} :
                               (db_w == 3'h2) ? {16'h0000, arg_q[15:0]} : arg_q[31:0];
  assign ack_enabled_out          = ack_en_q;
  assign ext_debug_status_reg_out = ext_debug_status_reg_q;
  assign debug_ctrl_reg_two_out   = ctrl2_q;
  assign debug_ctrl_reg_three_out = ctrl3_q;

  // Sequencer: take a code, gather arguments, run, then queue the answer.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= ST_IDLE;
      cmd_q      <= 8'h00;
      info_q     <= '0;
      arg_q      <= '0;
      cnt_q      <= 3'h0;
      resp_q     <= '0;
      resp_cnt_q <= 3'h0;
    end else if (busy_w) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: if (rx_take_w) begin
          cmd_q  <= rx_byte_in;
          info_q <= rx_info_w;
          cnt_q  <= rx_nargs_w;
          st_q   <= (rx_nargs_w == 3'h0) ? ST_EXEC : ST_ARGS;
        end
        ST_ARGS: if (rx_take_w) begin
          arg_q <= {arg_q[47:0], rx_byte_in};
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) st_q <= ST_EXEC;
        end
        ST_EXEC: if (done_w) begin
          resp_q     <= resp_w;
          resp_cnt_q <= resp_n_w;
          st_q       <= (resp_n_w == 3'h0) ? ST_IDLE : ST_RESP;
        end
        ST_RESP: if (fifo_ready) begin
          resp_q     <= {resp_q[31:0], 8'h00};
          resp_cnt_q <= resp_cnt_q - 3'h1;
          if (resp_cnt_q == 3'h1) st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Local effects of finished commands and the one-cycle pulses.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ack_en_q        <= 1'b0;
      ext_debug_status_reg_q          <= 8'h00;
      ctrl2_q         <= 8'h00;
      ctrl3_q         <= 8'h00;
      ack_pulse_out   <= 1'b0;
      resume_out      <= 1'b0;
      illegal_cmd_out <= 1'b0;
    end else begin
      ack_pulse_out   <= ack_w;
      resume_out      <= done_w && info_q.op == OP_GO && halted_in;
      illegal_cmd_out <= done_w && info_q.op == OP_ILLEGAL;
      if (done_w && info_q.op == OP_ACK_EN) ack_en_q <= 1'b1;
      if (done_w && info_q.op == OP_ACK_DIS) ack_en_q <= 1'b0;
      if (done_w && info_q.op == OP_BYTE_WR) begin
        if (cmd_q[1:0] == SEL_STATUS) ext_debug_status_reg_q <= arg_q[7:0];
        else if (cmd_q[1:0] == SEL_CTRL2) ctrl2_q <= arg_q[7:0];
        else ctrl3_q <= arg_q[7:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Answer buffer toward the bit framer
  // ------------------------------------------------------------------
  sdbg_byte_fifo #(
    .WIDTH (8),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_in       (ref_clk_in),
    .rst_n_in     (rst_n),
    .wr_data_in   (resp_q[39:32]),
    .wr_valid_in  (st_q == ST_RESP && !busy_w),
    .wr_ready_out (fifo_ready),
    .rd_data_out  (tx_byte_out),
    .rd_valid_out (tx_valid_out),
    .rd_ready_in  (tx_ready_in)
  );
endmodule

/* dv/sdbg_cmd_decoder_sva.sv */
// Concurrent checks on the ports of the debug command decoder.
// Assumes one clock and an active-low reset.
module sdbg_cmd_decoder_sva (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic debug_pin_in,
  input wire logic debug_pin_out,
  input wire logic debug_pin_oe_n_out,
  input wire logic rx_ready_out,
  input wire logic ack_pulse_out,
  input wire logic ack_enabled_out,
  input wire logic illegal_cmd_out,
  input wire logic halted_in,
  input wire logic resume_out,
  input wire logic acc_valid_out,
  input wire logic acc_done_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lo_cnt_q;
  logic [7:0] hi_cnt_q;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);
  // Run lengths of the driven-low reply and of a high pin.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lo_cnt_q <= 8'h00;
      hi_cnt_q <= 8'h00;
    end else begin
      lo_cnt_q <= (!debug_pin_oe_n_out && !debug_pin_out) ? lo_cnt_q + 8'h01 : 8'h00;
      hi_cnt_q <= debug_pin_in ? hi_cnt_q + {7'h00, hi_cnt_q != 8'hff} : 8'h00;
    end
  end
  // Reply high pulse and the release after it.
  sequence reply_hi_s;
    !debug_pin_oe_n_out && debug_pin_out;
  endsequence
  sequence released_s;
    debug_pin_oe_n_out ##1 debug_pin_oe_n_out;
  endsequence
  reply_len_a: assert property (reply_hi_s |-> lo_cnt_q == 8'h80)
    else $error("reply low not 128 cycles");
  pin_release_a: assert property (reply_hi_s |=> released_s)
    else $error("pin not released");
  sync_gap_a: assert property ($fell(debug_pin_oe_n_out) |-> hi_cnt_q >= 8'h10)
    else $error("reply gap under 16 cycles");
  sync_busy_a: assert property (!debug_pin_oe_n_out |-> !rx_ready_out)
    else $error("bytes taken in sync reply");
  ack_mode_a: assert property (ack_pulse_out |-> ack_enabled_out)
    else $error("acknowledge with handshake off");
  acc_hold_a: assert property (acc_valid_out && !acc_done_in |=> acc_valid_out)
    else $error("request dropped early");
  illegal_acc_a: assert property (illegal_cmd_out |-> !acc_valid_out ##1 !acc_valid_out)
    else $error("access for illegal code");
  resume_halt_a: assert property (resume_out |-> $past(halted_in))
    else $error("resume issued while running");
endmodule

bind sdbg_cmd_decoder sdbg_cmd_decoder_sva chk (
  .ref_clk_in, .resetn_in, .debug_pin_in, .debug_pin_out, .debug_pin_oe_n_out,
  .rx_ready_out, .ack_pulse_out, .ack_enabled_out, .illegal_cmd_out, .halted_in,
  .resume_out, .acc_valid_out, .acc_done_in
);

/* dv/sdbg_host_pod.sv */
// Behavioural debug host pod that asks the target for a speed reference.
// Assumes the bench adds a pull-up to the wire.
module sdbg_host_pod #(
  parameter int LOW_CYC = 140
) (
  input  wire logic clk_in,
  input  wire logic pin_in,
  output logic      oe_n_out = 1'b1,
  output logic      drv_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Long low, short high, release, then time the reply's low phase.
  task automatic sync(output int low_cyc);
    int n;
    low_cyc = 0;
    oe_n_out = 1'b0;
    drv_out = 1'b0;
    repeat (LOW_CYC) @(posedge clk_in);
    #1;
    drv_out = 1'b1;
    @(posedge clk_in);
    #1;
    oe_n_out = 1'b1;
    for (n = 0; pin_in !== 1'b0 && n < 100; n++) begin
      @(posedge clk_in);
      #1;
    end
    while (pin_in === 1'b0 && low_cyc < 400) begin
      @(posedge clk_in);
      #1;
      low_cyc++;
    end
  endtask
endmodule

/* dv/tb_single_pin_debug_cmd_decoder.sv */
// Self-checking bench for the debug command decoder and a host pod model.
// Assumes package, decoder, FIFO, checker and pod are compiled first.
module tb_single_pin_debug_cmd_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import sdbg_pkg::*;
  logic             ref_clk_in = 1'b0, resetn_in = 1'b0, rx_valid_in = 1'b0;
  logic             tx_ready_in = 1'b0, acc_done_in = 1'b0, halted_in = 1'b0;
  logic       [7:0] rx_byte_in = 8'h00;
  logic      [31:0] acc_rdata_in = 32'h0;
  logic             debug_pin_out, debug_pin_oe_n_out, rx_ready_out, tx_valid_out;
  logic             ack_pulse_out, ack_enabled_out, illegal_cmd_out, resume_out;
  logic             acc_valid_out, pod_oe_n, pod_drv;
  logic       [7:0] tx_byte_out, ext_debug_status_reg_out;
  logic       [7:0] debug_ctrl_reg_two_out, debug_ctrl_reg_three_out, st_v, bv[3];
  logic      [23:0] addr_v;
  logic      [31:0] wd_v;
  logic       [7:0] exp_q[$];
  sdbg_acc_req_type acc_req_out, last_req;
  wire logic        debug_pin_in;
  int               miscompares, checks_done, acks, ills, resumes, meas, n, sz, ws;
  // Open-drain wire with a pull-up.
  assign debug_pin_in = !debug_pin_oe_n_out ? debug_pin_out : (!pod_oe_n ? pod_drv : 1'b1);
  // Free-running 125 MHz clock.
  always #4 ref_clk_in = ~ref_clk_in;
  sdbg_cmd_decoder dut (.ref_clk_in, .resetn_in, .debug_pin_in, .debug_pin_out,
    .debug_pin_oe_n_out, .rx_byte_in, .rx_valid_in, .rx_ready_out, .tx_byte_out,
    .tx_valid_out, .tx_ready_in, .ack_pulse_out, .ack_enabled_out, .illegal_cmd_out,
    .halted_in, .resume_out, .acc_valid_out, .acc_req_out, .acc_done_in, .acc_rdata_in,
    .ext_debug_status_reg_out, .debug_ctrl_reg_two_out, .debug_ctrl_reg_three_out);
  sdbg_host_pod pod (.clk_in(ref_clk_in), .pin_in(debug_pin_in), .oe_n_out(pod_oe_n),
    .drv_out(pod_drv));
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Counts one comparison; reports a mismatch.
  task automatic check(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  // Scoreboard, pulse counters, stalling sink and processor side.
  always @(posedge ref_clk_in) begin
    if (tx_valid_out === 1'b1 && tx_ready_in) begin
      if (exp_q.size() == 0) check(1'b0, "unexpected answer byte");
      else check(tx_byte_out === exp_q.pop_front(), "answer byte");
    end
    if (ack_pulse_out === 1'b1) acks++;
    if (illegal_cmd_out === 1'b1) ills++;
    if (resume_out === 1'b1) resumes++;
    #1;
    tx_ready_in = ($urandom % 4) != 0;
    if (acc_done_in) acc_done_in = 1'b0;
    else if (acc_valid_out === 1'b1 && ($urandom % 2) != 0) begin
      acc_done_in = 1'b1;
      last_req = acc_req_out;
    end
  end
  // Waits c clock edges and steps off the edge.
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk_in);
    #1;
  endtask
  // Holds one byte until the decoder takes it.
  task automatic put(input logic [7:0] b);
    int k;
    rx_byte_in = b;
    rx_valid_in = 1'b1;
    for (k = 0; rx_ready_out !== 1'b1; k++) begin
      if (k > 500) begin
        check(1'b0, "byte refused too long");
        wrap_up();
      end
      tick(1);
    end
    tick(1);
  endtask
  // One command; st places status: 0 none, 1 first, 2 last.
  task automatic xfer(input logic [7:0] code, input int na, nw, nr, st, ak, il);
    int a0, i0, k;
    a0 = acks;
    i0 = ills;
    if (st == 1) exp_q.push_back(st_v);
    for (k = nr - 1; k >= 0; k--) exp_q.push_back(acc_rdata_in[8*k +: 8]);
    if (st == 2) exp_q.push_back(st_v);
    put(code);
    for (k = na - 1; k >= 0; k--) put(addr_v[8*k +: 8]);
    for (k = nw - 1; k >= 0; k--) put(wd_v[8*k +: 8]);
    rx_valid_in = 1'b0;
    rx_byte_in = ~rx_byte_in;
    for (k = 0; exp_q.size() != 0 || acc_valid_out === 1'b1 || rx_ready_out !== 1'b1; k++) begin
      if (k > 900) begin
        check(1'b0, "command never finished");
        wrap_up();
      end
      tick(1);
    end
    tick(3);
    check(acks - a0 == ak, "acknowledge count");
    check(ills - i0 == il, "illegal count");
  endtask
  // Main sequence of scenarios.
  initial begin
    void'($urandom(72621));
    tick(8);
    resetn_in = 1'b1;
    tick(3);
    check(ack_enabled_out === 1'b0 && tx_valid_out === 1'b0, "reset state");
    xfer(8'h02, 0, 0, 0, 0, 1, 0);
    check(ack_enabled_out === 1'b1, "handshake on");
    $display("test reset and handshake done");
    for (n = 0; n < 3; n++) begin
      wd_v = $urandom;
      bv[n] = wd_v[7:0];
      xfer(8'h0d + 8'(n), 0, 1, 0, 0, 0, 0);
      exp_q.push_back(bv[n]);
      xfer(8'h2d + 8'(n), 0, 0, 0, 0, 0, 0);
    end
    st_v = bv[0];
    check(ext_debug_status_reg_out === bv[0] && debug_ctrl_reg_two_out === bv[1]
      && debug_ctrl_reg_three_out === bv[2], "byte registers");
    $display("test byte registers done");
    for (sz = 0; sz < 3; sz++) for (ws = 0; ws < 2; ws++) begin
      addr_v = 24'($urandom);
      wd_v = $urandom;
      acc_rdata_in = $urandom;
      xfer(8'h30 + 8'(4 * sz + ws), 3, 0, 1 << sz, ws, 1 - ws, 0);
      check(last_req.addr === addr_v && last_req.size === 2'(sz), "read request");
      xfer(8'h10 + 8'(4 * sz + ws), 3, 1 << sz, 0, 2 * ws, 1 - ws, 0);
      check(last_req.wdata === (wd_v & ~(32'hffffffff << (8 << sz)))
        && last_req.addr === addr_v, "write request");
    end
    $display("test memory access done");
    halted_in = 1'b1;
    acc_rdata_in = $urandom;
    wd_v = $urandom;
    xfer(8'h63, 0, 0, 4, 0, 1, 0);
    xfer(8'h45, 0, 4, 0, 0, 1, 0);
    check(last_req.wdata === wd_v && last_req.reg_num === 5'h05, "register write");
    xfer(8'hc2, 0, 4, 0, 0, 1, 0);
    xfer(8'h08, 0, 0, 0, 0, 1, 0);
    halted_in = 1'b0;
    xfer(8'h08, 0, 0, 0, 0, 1, 0);
    xfer(8'h87, 0, 4, 0, 0, 1, 0);
    xfer(8'h41, 0, 0, 4, 0, 1, 0);
    xfer(8'h01, 0, 0, 0, 0, 1, 0);
    xfer(8'h63, 0, 0, 0, 0, 0, 1);
    xfer(8'hc2, 0, 0, 0, 0, 0, 1);
    check(resumes == 1, "resume count");
    $display("test run and halt commands done");
    xfer(8'h03, 0, 0, 0, 0, 0, 0);
    check(ack_enabled_out === 1'b0, "handshake off");
    xfer(8'h00, 0, 0, 0, 0, 0, 0);
    $display("test handshake off done");
    put(8'h30);
    put(8'h12);
    rx_valid_in = 1'b0;
    rx_byte_in = ~rx_byte_in;
    pod.sync(meas);
    check(meas == 128, "sync reply length");
    exp_q.push_back(bv[1]);
    xfer(8'h2e, 0, 0, 0, 0, 0, 0);
    $display("test sync done");
    wrap_up();
  end
endmodule
